// [rtl/burst_fifo.sv]
// Purpose: valid/ready fifo, width and depth as parameters
// Assumes: depth is a power of two
// Notes:   full and empty come from pointer distance
`timescale 1ns/100ps
module burst_fifo #(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             CORE_CLK_IN,
    input  wire logic             RESETN_IN,
    input  wire logic             CLK_EN_IN,
    input  wire logic             IN_VALID_IN,
    output logic                  IN_READY_OUT,
    input  wire logic [WIDTH-1:0] IN_DATA_IN,
    output logic                  OUT_VALID_OUT,
    input  wire logic             OUT_READY_IN,
    output logic [WIDTH-1:0]      OUT_DATA_OUT
);
    localparam int unsigned PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_ptr;
    logic [PW:0]      rd_ptr;
    wire              push = IN_VALID_IN && IN_READY_OUT && CLK_EN_IN;
    wire              pop  = OUT_VALID_OUT && OUT_READY_IN && CLK_EN_IN;
    wire [PW:0]       fill = wr_ptr - rd_ptr;
    wire [PW:0]       next_fill = fill + (PW+1)'(push) - (PW+1)'(pop);
    logic             not_full;

    ////////////////////////////////////////////////////////////////
    // flags: full stalls the source; ready comes from a flop, at the
    // price of working out the fill one cycle ahead
    assign IN_READY_OUT  = not_full;
    assign OUT_VALID_OUT = (fill != '0);
    assign OUT_DATA_OUT  = mem[rd_ptr[PW-1:0]];

    // pointers
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            not_full <= 1'b1;
        end
        else
        begin
            not_full <= (next_fill != (PW+1)'(DEPTH));
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop)  rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // storage, no reset needed
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (push) mem[wr_ptr[PW-1:0]] <= IN_DATA_IN;
    end
endmodule : burst_fifo

// [rtl/burst_sram_ctrl.sv]
// Purpose: controller end; queues bursts, drives the beat phase and pins
// Assumes: user pushes whole requests into the fifo
// Notes:   one read word pair returns on RD_DATA_OUT, word order kept
`timescale 1ns/100ps
module burst_sram_ctrl #(
    parameter int unsigned WORD_W = burst_sram_pkg::WORD_W,
    parameter int unsigned ADDR_W = burst_sram_pkg::ADDR_W
) (
    input  wire logic                  CORE_CLK_IN,
    input  wire logic                  RESETN_IN,
    input  wire logic                  CLK_EN_IN,
    input  wire logic                  REQ_VALID_IN,
    output logic                       REQ_READY_OUT,
    input  wire logic                  REQ_READ_IN,
    input  wire logic [ADDR_W-1:0]     REQ_ADDR_IN,
    input  wire logic [2*WORD_W-1:0]   REQ_DATA_IN,
    input  wire logic [2*WORD_W/9-1:0] REQ_SEL_N_IN,
    output logic                       RD_VALID_OUT,
    output logic [2*WORD_W-1:0]        RD_DATA_OUT,
    burst_sram_if.ctrl                 link
);
    localparam int unsigned LN = WORD_W / burst_sram_pkg::LANE_W;
    localparam int unsigned RW = 1 + ADDR_W + 2*WORD_W + 2*LN;
    logic [RW-1:0] q_data;
    logic          q_valid;
    logic          phase;
    logic          second;
    logic [WORD_W-1:0] hi_word;
    logic [LN-1:0]     hi_sel;
    logic [1:0]    rd_pipe;
    logic [1:0]    rd_cap;
    logic [WORD_W-1:0] rd_first;
    logic [WORD_W-1:0] dq_s1;
    logic [WORD_W-1:0] dq_s2;
    logic          vld_s1;
    logic          vld_s2;
    logic          rd_last;

    wire q_rd = q_data[RW-1];
    // a write right after a read would meet the read's second word on
    // the data wire, so one true slot is skipped for the turnaround
    wire hold_wr = rd_last && !q_rd;
    // fifo takes only while the link is on a complementary slot, so the load goes out on the next true slot; hold_wr holds a write back
    wire take = q_valid && !phase && !hold_wr && CLK_EN_IN;

    burst_fifo #(.WIDTH(RW), .DEPTH(burst_sram_pkg::FIFO_DEPTH)) u_fifo (
        .CORE_CLK_IN  (CORE_CLK_IN),
        .RESETN_IN    (RESETN_IN),
        .CLK_EN_IN    (CLK_EN_IN),
        .IN_VALID_IN  (REQ_VALID_IN),
        .IN_READY_OUT (REQ_READY_OUT),
        .IN_DATA_IN   ({REQ_READ_IN, REQ_ADDR_IN, REQ_DATA_IN, REQ_SEL_N_IN}),
        .OUT_VALID_OUT(q_valid),
        .OUT_READY_IN (!phase && !hold_wr),
        .OUT_DATA_OUT (q_data)
    );

    ////////////////////////////////////////////////////////////////
    // drive pins: true slot loads, complementary slot sends word two
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            phase                 <= 1'b0;
            second                <= 1'b0;
            hi_word               <= '0;
            hi_sel                <= '1;
            rd_last               <= 1'b0;
            link.beat_phase       <= 1'b1;  // opposite of phase, slots alternate from the first edge
            link.cycle_load_n     <= 1'b1;
            link.rw_dir           <= 1'b1;
            link.addr             <= '0;
            link.byte_write_sel_n <= '1;
            link.dq_ctrl_out      <= '0;
            link.dq_ctrl_oe       <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            phase           <= ~phase;
            link.beat_phase <= phase;
            // remember a read load for the turnaround
            if (!phase)
                rd_last <= take && q_rd;
            if (take)
            begin
                link.cycle_load_n     <= 1'b0;
                link.rw_dir           <= q_rd;
                link.addr             <= q_data[RW-2 -: ADDR_W];
                link.dq_ctrl_out      <= q_data[2*LN +: WORD_W];
                link.byte_write_sel_n <= q_data[LN-1:0];
                link.dq_ctrl_oe       <= !q_rd;
                hi_word               <= q_data[2*LN+WORD_W +: WORD_W];
                hi_sel                <= q_data[2*LN-1:LN];
                second                <= !q_rd;
            end
            else
            begin
                link.cycle_load_n     <= 1'b1;
                link.dq_ctrl_out      <= hi_word;
                link.byte_write_sel_n <= second ? hi_sel : {LN{1'b1}};
                link.dq_ctrl_oe       <= second;
                second                <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // read return: pins pass two flops, then pair words
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            dq_s1        <= '0;
            dq_s2        <= '0;
            vld_s1       <= 1'b0;
            vld_s2       <= 1'b0;
            rd_cap       <= 2'h0;
            rd_first     <= '0;
            RD_VALID_OUT <= 1'b0;
            RD_DATA_OUT  <= '0;
        end
        else if (CLK_EN_IN)
        begin
            dq_s1  <= link.dq_in;
            dq_s2  <= dq_s1;
            vld_s1 <= link.read_valid_flag;
            vld_s2 <= vld_s1;
            RD_VALID_OUT <= 1'b0;
            if (vld_s2 && rd_cap == 2'h0)
            begin
                rd_first <= dq_s2;
                rd_cap   <= 2'h1;
            end
            else if (vld_s2)
            begin
                RD_DATA_OUT  <= {dq_s2, rd_first};
                RD_VALID_OUT <= 1'b1;
                rd_cap       <= 2'h0;
            end
        end
    end
endmodule : burst_sram_ctrl

// [rtl/burst_sram_if.sv]
// Purpose: pin bundle between memory controller and burst sram
// Assumes: the bench resolves the shared data wire from the two enables
// Notes:   beat_phase high marks the complementary-clock slot
`timescale 1ns/100ps
interface burst_sram_if #(
    parameter int unsigned WORD_W = 18,
    parameter int unsigned ADDR_W = 21
);
    logic                  beat_phase;        // 0 true edge, 1 complementary edge
    logic                  cycle_load_n;
    logic                  rw_dir;            // 1 read, 0 write
    logic [ADDR_W-1:0]     addr;
    logic [WORD_W/9-1:0]   byte_write_sel_n;
    logic [WORD_W-1:0]     dq_ctrl_out;
    logic                  dq_ctrl_oe;
    logic [WORD_W-1:0]     dq_mem_out;
    logic                  dq_mem_oe;
    logic [WORD_W-1:0]     dq_in;             // resolved wire level
    logic                  read_valid_flag;
    logic                  echo_output_strobe;

    modport ctrl (output beat_phase, cycle_load_n, rw_dir, addr, byte_write_sel_n,
                  dq_ctrl_out, dq_ctrl_oe, input dq_in, read_valid_flag, echo_output_strobe);
    modport mem  (input beat_phase, cycle_load_n, rw_dir, addr, byte_write_sel_n, dq_in,
                  output dq_mem_out, dq_mem_oe, read_valid_flag, echo_output_strobe);
endinterface : burst_sram_if

// [rtl/burst_sram_mem.sv]
// Purpose: memory end of the two-word burst pin link
// Assumes: controller alternates beat_phase every core cycle
// Notes:   two equal arrays, even word and odd word of each burst
//          both clock phases are modelled as alternate core cycles,
//          so one burst occupies two core cycles on the pins
//          outputs are registered; the drive falls without a command
//
// Summary of operation
// - write data captured on both beat edges
// - read words driven on both beat edges
// - drivers off whenever no read active
// - load strobe low starts cycle, true edge
// - exactly two words per loaded address
// - only selected byte lanes are stored
// - each select owns one nine-bit lane
// - selects sampled with their data beat
// - shared address captured at load edge
// - two equal internal arrays of words
// - direction high reads, low writes
// - every access starts on true edge
// - valid flag high while read data driven
`timescale 1ns/100ps
module burst_sram_mem #(
    parameter int unsigned WORD_W   = burst_sram_pkg::WORD_W,
    parameter int unsigned ARRAY_AW = burst_sram_pkg::ARRAY_AW
) (
    input  wire logic  CORE_CLK_IN,
    input  wire logic  RESETN_IN,
    input  wire logic  CLK_EN_IN,
    burst_sram_if.mem  link,
    output logic       BUSY_OUT
);
    // local sizes
    localparam int unsigned LANE_W = burst_sram_pkg::LANE_W;
    localparam int unsigned LANES  = WORD_W / LANE_W;
    localparam int unsigned DEPTH  = 2**ARRAY_AW;

    // two equal arrays, even and odd word
    // depth is shrunk so the bench stays small; a full part
    // would widen ARRAY_AW to the whole loaded address
    logic [WORD_W-1:0]   array_even [DEPTH];
    logic [WORD_W-1:0]   array_odd  [DEPTH];

    // burst state
    logic [ARRAY_AW-1:0] cur_addr;   // address of the burst in flight
    logic                wr_second;  // write word two due next slot
    logic                rd_second;  // read word two due next slot
    logic [WORD_W-1:0]   rd_hold;    // odd word parked for its slot
    logic [WORD_W-1:0]   wr_mask;

    // registered pin and status values
    logic [WORD_W-1:0]   dq_out;
    logic                dq_oe;
    logic                rd_valid;
    logic                echo;
    logic                busy;

    ////////////////////////////////////////////////////////////////
    // decode of the loaded cycle
    // strobe on true edge
    wire                 on_true   = CLK_EN_IN && (link.beat_phase == burst_sram_pkg::BEAT_TRUE);
    wire                 on_comp   = CLK_EN_IN && (link.beat_phase == burst_sram_pkg::BEAT_COMP);
    wire                 load_seen = on_true && !link.cycle_load_n;
    wire                 ld_read   = load_seen && (link.rw_dir == burst_sram_pkg::DIR_READ);
    wire                 ld_write  = load_seen && (link.rw_dir == burst_sram_pkg::DIR_WRITE);
    // one address bus for both directions
    wire [ARRAY_AW-1:0]  ld_addr   = link.addr[ARRAY_AW-1:0];
    // a load in the complementary slot is ignored, so word two
    // can only follow a load taken one slot earlier
    wire                 wr_beat2  = wr_second && on_comp;
    wire                 rd_beat   = ld_read || rd_second;

    ////////////////////////////////////////////////////////////////
    // byte lane masks
    // nine-bit lane masks
    // a high select leaves its lane out of the merge below
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            assign wr_mask[g*LANE_W +: LANE_W] = {LANE_W{~link.byte_write_sel_n[g]}};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // merged write words
    // masked lanes untouched
    // read-modify-write keeps unselected lanes; costs a read
    // port per array but needs no per-lane write enables
    wire [WORD_W-1:0]    next_even = (array_even[ld_addr] & ~wr_mask) | (link.dq_in & wr_mask);
    wire [WORD_W-1:0]    next_odd  = (array_odd[cur_addr] & ~wr_mask) | (link.dq_in & wr_mask);

    // read word selection
    // even word first, odd word second
    wire [WORD_W-1:0]    next_dq   = ld_read ? array_even[ld_addr] : rd_hold;

    ////////////////////////////////////////////////////////////////
    // burst sequencing
    // access start at true edge
    // the flags last one slot; a load in the next true slot
    // simply starts another burst
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            cur_addr  <= '0;
            wr_second <= 1'b0;
            rd_second <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            if (load_seen)
                cur_addr <= ld_addr;
            wr_second <= ld_write;
            rd_second <= ld_read;
        end
    end

    ////////////////////////////////////////////////////////////////
    // storage
    // arrays carry no reset: contents are undefined at power-up
    // capture both beats
    // word one lands at the load edge
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (ld_write)
            array_even[ld_addr] <= next_even;
    end

    // word two lands one slot later, same address
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (wr_beat2)
            array_odd[cur_addr] <= next_odd;
    end

    // odd word parked at the load so each array sees one read
    // a read in the next true slot overwrites it only after use
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            rd_hold <= '0;
        else if (ld_read)
            rd_hold <= array_odd[ld_addr];
    end

    ////////////////////////////////////////////////////////////////
    // output drive, registered
    // launch word per edge
    // dq_out keeps its last word while idle; the enable alone
    // decides whether it reaches the wire
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            dq_out <= '0;
        else if (CLK_EN_IN && rd_beat)
            dq_out <= next_dq;
    end

    // valid with data
    // drive and valid fall the slot after the burst, no command
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            dq_oe    <= 1'b0;
            rd_valid <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            dq_oe    <= rd_beat;
            rd_valid <= rd_beat;
        end
    end

    // echo strobe marks the true slot on the output side
    // it runs free, with or without a burst in flight
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            echo <= 1'b0;
        else if (CLK_EN_IN)
            echo <= ~link.beat_phase;
    end

    // busy pulses once per taken load
    // not used by the link itself; a status tap for the system
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            busy <= 1'b0;
        else if (CLK_EN_IN)
            busy <= load_seen;
    end

    ////////////////////////////////////////////////////////////////
    // pins and status straight from the flops above
    // one continuous driver per interface output
    assign link.dq_mem_out         = dq_out;
    assign link.dq_mem_oe          = dq_oe;
    assign link.read_valid_flag    = rd_valid;
    assign link.echo_output_strobe = echo;
    assign BUSY_OUT                = busy;
endmodule : burst_sram_mem

// [rtl/burst_sram_pkg.sv]
// Purpose: shared constants for the two-word burst sram pin link
// Assumes: one 10 MHz core clock; both clock phases modelled as beat slots
// Notes:   widths are defaults, the array depth is shrunk for simulation
package burst_sram_pkg;
    localparam int unsigned WORD_W      = 18;  // narrow configuration
    localparam int unsigned LANE_W      = 9;   // one byte lane
    localparam int unsigned ADDR_W      = 21;  // loaded addresses, x18
    localparam int unsigned BURST_LEN   = 2;   // words per loaded address
    localparam int unsigned ARRAY_AW    = 6;   // simulated depth per array
    localparam int unsigned FIFO_DEPTH  = 16;
    localparam logic        BEAT_TRUE   = 1'b0;  // first beat slot
    localparam logic        BEAT_COMP   = 1'b1;  // second beat slot
    localparam logic        DIR_READ    = 1'b1;
    localparam logic        DIR_WRITE   = 1'b0;
endpackage : burst_sram_pkg

// [sim/burst_sram_pin_interface_bench.sv]
// Purpose: drives requests into the controller, checks words read back
// Assumes: both ends run every cycle, clock enable held high
// Notes:   model keeps {word2,word1} per address; released wire inverts
`timescale 1ns/100ps
module burst_sram_pin_interface_bench;
    logic        core_clk;
    logic        resetn;
    logic        req_valid;
    logic        req_ready;
    logic        req_read;
    logic [20:0] req_addr;
    logic [35:0] req_data;
    logic [3:0]  req_sel_n;
    logic        rd_valid;
    logic [35:0] rd_data;
    logic [17:0] last_dq = '0;
    logic        stall_seen = 1'b0;
    logic        mem_busy;
    int          busy_count = 0;
    logic [35:0] model [64];
    logic [35:0] rd_q [$];
    logic [17:0] wire_q [$];
    int          mismatches = 0;
    int          cmp_count = 0;
    burst_sram_if #(.WORD_W(18), .ADDR_W(21)) link ();
    burst_sram_ctrl i_burst_sram_ctrl (.CORE_CLK_IN(core_clk), .RESETN_IN(resetn), .CLK_EN_IN(1'b1),
        .REQ_VALID_IN(req_valid), .REQ_READY_OUT(req_ready), .REQ_READ_IN(req_read),
        .REQ_ADDR_IN(req_addr), .REQ_DATA_IN(req_data), .REQ_SEL_N_IN(req_sel_n),
        .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data), .link(link.ctrl));
    burst_sram_mem i_burst_sram_mem (.CORE_CLK_IN(core_clk), .RESETN_IN(resetn), .CLK_EN_IN(1'b1),
        .link(link.mem), .BUSY_OUT(mem_busy));
    burst_sram_props i_burst_sram_props (.CORE_CLK_IN(core_clk), .RESETN_IN(resetn),
        .beat_phase(link.beat_phase), .cycle_load_n(link.cycle_load_n), .rw_dir(link.rw_dir),
        .dq_ctrl_oe(link.dq_ctrl_oe), .dq_mem_oe(link.dq_mem_oe), .read_valid_flag(link.read_valid_flag));
    ////////////////////////////////////////////////////////////////
    // wire level: released bus shows inverse so stale data cannot pass
    assign link.dq_in = link.dq_mem_oe ? link.dq_mem_out : (link.dq_ctrl_oe ? link.dq_ctrl_out : ~last_dq);
    // monitors for returned pairs, wire words and fifo back-pressure
    always @(posedge core_clk)
    begin
        last_dq <= link.dq_in;
        if (rd_valid === 1'b1) rd_q.push_back(rd_data);
        if (mem_busy === 1'b1) busy_count++;
        if (link.dq_mem_oe === 1'b1) wire_q.push_back(link.dq_mem_out);
        if (req_valid && req_ready === 1'b0) stall_seen <= 1'b1;
    end
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // request held until ready seen settled before an edge
    task automatic push(input logic rd, input logic [20:0] a, input logic [35:0] d, input logic [3:0] s);
        req_valid = 1'b1;
        req_read  = rd;
        req_addr  = a;
        req_data  = d;
        req_sel_n = s;
        while (req_ready !== 1'b1) begin @(posedge core_clk); #1; end
        @(posedge core_clk);
        #1;
        if (!rd) for (int g = 0; g < 4; g++) if (!s[g]) model[a[5:0]][9*g +: 9] = d[9*g +: 9];
    endtask : push
    // stop requesting, wait for n pairs, compare against the model
    task automatic drain(input int n, input logic [5:0] a0, input int step);
        req_valid = 1'b0;
        for (int k = 0; k < 200 && rd_q.size() < n; k++) @(posedge core_clk);
        #1;
        check(36'(rd_q.size()), 36'(n));
        for (int i = 0; i < n && rd_q.size() > 0; i++) check(rd_q.pop_front(), model[6'(a0 + i*step)]);
    endtask : drain
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////
    // hang guard, well beyond the few hundred cycles used
    initial
    begin
        repeat (8000) @(posedge core_clk);
        mismatches++;
        $display("unexpected at %0t: cycles got %h expected below %h", $time, 16'h1F40, 16'h1F40);
        wrap_up();
    end
    initial
    begin
        {resetn, req_valid, req_read, req_addr, req_data, req_sel_n} = '0;
        repeat (2) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        // basic pair, word order on the wire
        wire_q.delete();
        push(1'b0, 21'h05, 36'hA_BCDE_F012, 4'h0);
        push(1'b1, 21'h05, 36'h0, 4'h0);
        drain(1, 6'h05, 0);
        check(36'(wire_q.size()), 36'h2);
        check(36'(wire_q[0]), 36'h0_0002_F012);
        check(36'(wire_q[1]), 36'h0_0002_AF37);
        check(36'(link.dq_mem_oe), 36'h0);
        check(36'(busy_count), 36'h2);
        $display("test basic pair done");
        // every lane select code, back to back, on a known background
        for (int c = 0; c < 16; c++) push(1'b0, 21'(16 + c), 36'hF_FFFF_FFFF, 4'h0);
        for (int c = 0; c < 16; c++) push(1'b0, 21'(16 + c), 36'h1_2345_6789 ^ 36'(c), 4'(c));
        for (int c = 0; c < 16; c++) push(1'b1, 21'(16 + c), 36'h0, 4'h0);
        drain(16, 6'd16, 1);
        $display("test byte lanes done");
        // fifo filled past its depth, then the ends read back
        for (int i = 0; i < 40; i++) push(1'b0, 21'(20 + i), {18'(i), 18'h3_FFFF ^ 18'(i)}, 4'h0);
        push(1'b1, 21'd20, 36'h0, 4'h0);
        push(1'b1, 21'd59, 36'h0, 4'h0);
        drain(2, 6'd20, 39);
        check(36'(stall_seen), 36'h1);
        $display("test fifo fill done");
        // read, write, read: the write waits one slot for the wire
        push(1'b1, 21'd20, 36'h0, 4'h0);
        push(1'b0, 21'd21, 36'h5_A5A5_A5A5, 4'h0);
        push(1'b1, 21'd21, 36'h0, 4'h0);
        drain(2, 6'd20, 1);
        $display("test turnaround done");
        wrap_up();
    end
endmodule : burst_sram_pin_interface_bench

// [sim/burst_sram_props.sv]
// Purpose: pin-level checks on the link between controller and memory
// Assumes: one clock; loads are taken only in the true beat slot
// Notes:   sees the interface signals only
`timescale 1ns/100ps
module burst_sram_props (
    input wire logic CORE_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic beat_phase,
    input wire logic cycle_load_n,
    input wire logic rw_dir,
    input wire logic dq_ctrl_oe,
    input wire logic dq_mem_oe,
    input wire logic read_valid_flag
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    // decoded loads, as the memory takes them
    wire load_taken = !beat_phase && !cycle_load_n;
    wire rd_load    = load_taken && rw_dir;
    wire wr_load    = load_taken && !rw_dir;
    ////////////////////////////////////////////////////////////////
    // two beats per burst, slots alternate
    sequence s_rd_burst;
        (dq_mem_oe && beat_phase) ##1 (dq_mem_oe && !beat_phase);
    endsequence
    sequence s_wr_burst;
        dq_ctrl_oe ##1 (dq_ctrl_oe && beat_phase);
    endsequence
    a_read_two_beats: assert property (rd_load |=> s_rd_burst)
        else $error("read burst not driven for two beats");
    a_write_two_beats: assert property (wr_load |-> s_wr_burst)
        else $error("write burst not driven for two beats");
    a_idle_tristate: assert property (dq_mem_oe |-> ($past(rd_load) || $past(rd_load, 2)))
        else $error("memory drives data with no read loaded");
    a_valid_tracks_oe: assert property (read_valid_flag == dq_mem_oe)
        else $error("valid flag differs from data drive");
    a_no_contention: assert property (!(dq_ctrl_oe && dq_mem_oe))
        else $error("both ends drive the data wire");
    a_load_true_slot: assert property (!cycle_load_n |-> !beat_phase)
        else $error("load strobe in the complementary slot");
    a_phase_alternates: assert property ($past(RESETN_IN) |-> beat_phase != $past(beat_phase))
        else $error("beat phase did not alternate");
    a_write_no_valid: assert property (wr_load |=> !read_valid_flag)
        else $error("write load answered with read data");
endmodule : burst_sram_props
